/* logic/ifg_irq_gpio.sv */
// What this block does
// RQ1 - flags 0..4: rx ready, rx discarded, tx sent, retry limit, checksum error
// RQ2 - flag 5 tx fifo under/overflow, flag 6 rx fifo under/overflow
// RQ3 - flags 7..10: tx almost full/empty, rx almost full/empty
// RQ4 - flag 11 when back-off attempts are exhausted
// RQ5 - flags 12..14: preamble, sync word, carrier sense
// RQ6 - flag 15 wake-up timeout set only once oscillator clock is available
// RQ7 - flag 16 on each entry to READY with oscillator settled
// RQ8 - flags 17,18,19 standby move, low battery, power-on; 28,29 timer timeouts
// RQ9 - flags go high on event and clear when the host reads them
// RQ10 - a zero mask bit keeps its event from requesting
// RQ11 - output selection 0 drives the active-low event request
// RQ12 - selections 1..3: inverted power-on, wake-up expiry, low battery
// RQ13 - selections 4, 8, 9: tx data clock, rx data, rx recovered clock
// RQ14 - selections 5, 10, 18: tx state, rx state, tx-or-rx activity
// RQ15 - selections 6 and 7: fifo almost empty and almost full
// RQ16 - selection 11 low in sleep/standby; 12,22,23,24 state marks
// RQ17 - selections 13..16: antenna switch, preamble, sync, carrier sense
// RQ18 - selection 19 constant high, 20 constant low
// RQ19 - selection 21 regulator enable; 25,27..29 internal waits, 26 keyed tx data, 30 synthesizer full; 17,31 reserved
// RQ20 - input selections 0..3: tx cmd, rx cmd, tx data, wake-up
// RQ21 - input selection 4 low-frequency clock; 5..31 do nothing
// RQ22 - two-bit pin mode: 01 input, 10 low drive, 11 high drive
// RQ23 - request stays low while any unmasked flag is set
`timescale 1ns/10ps
`include "ifg_regs.svh"
module ifg_irq_gpio #(
  parameter int NPIN = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire ifg_pkg::ifg_reg_req_t reg_req,
  output logic      [7:0]            reg_rdata,
  input  wire logic [31:0]           events,
  input  wire logic                  wakeup_timer_timeout,
  input  wire logic                  crystal_oscillator_clk_avail,
  input  wire logic                  crystal_oscillator_ready,
  input  wire ifg_pkg::ifg_src_t     src,
  input  wire logic [NPIN-1:0]       gpio_i,
  output logic      [NPIN-1:0]       gpio_o,
  output logic      [NPIN-1:0]       gpio_oe,
  output logic      [NPIN-1:0]       gpio_hd,
  output ifg_pkg::ifg_pin_fn_t       pin_fn,
  output logic                       event_request_n
);
  typedef struct packed {
    logic [NPIN-1:0][7:0] conf;
    logic [31:0]          mask;
    logic [31:0]          flags;
    logic                 wut_pend;
    logic                 rdy_prev;
    logic                 req_n;
    logic [7:0]           rdata;
  } ifg_main_st_t;

  localparam ifg_main_st_t RST_ST = '{
    conf:     {{(NPIN-1){`IFG_CONFN_RST}}, `IFG_CONF0_RST},
    mask:     `IFG_MASK_RST,
    flags:    `IFG_FLAG_RST,
    wut_pend: 1'b0,
    rdy_prev: 1'b0,
    req_n:    1'b1,
    rdata:    8'h00
  };

  ifg_main_st_t      st_q;
  ifg_main_st_t      st_d;
  ifg_pkg::ifg_src_t src_full;
  logic [NPIN-1:0]   gpio_s;
  logic [31:0]       ev;
  logic [31:0]       clr;
  logic              ready_now;

  // one-hot byte lane of a four-byte register, lowest address is the top byte
  function automatic logic [31:0] lane_bits(input logic [7:0] addr, input logic [7:0] base);
    lane_bits = '0;
    if (addr[7:2] == base[7:2]) begin
      lane_bits = `IFG_LANE0_MASK >> {addr[1:0], 3'b000};
    end
  endfunction

  function automatic logic [7:0] pick_byte(input logic [31:0] word, input logic [1:0] idx);
    pick_byte = 8'(word >> (`IFG_LANE_SHIFT - {idx, 3'b000}));
  endfunction

  assign ready_now = src.st_ready & crystal_oscillator_ready;

  always_comb begin
    logic [31:0] mlane;
    logic [31:0] flane;
    st_d  = st_q;
    mlane = lane_bits(reg_req.addr, `IFG_MASK_BASE);
    flane = lane_bits(reg_req.addr, `IFG_FLAG_BASE);
    // RQ1 RQ2 RQ3 RQ4 RQ5 RQ8 event flag positions
    ev = events & `IFG_EXT_FLAGS;
    // RQ6 hold timeout until oscillator clock
    ev[`IFG_F_WUT] = (st_q.wut_pend | wakeup_timer_timeout) & crystal_oscillator_clk_avail;
    st_d.wut_pend  = (st_q.wut_pend | wakeup_timer_timeout) & ~crystal_oscillator_clk_avail;
    // RQ7 ready entry edge
    ev[`IFG_F_READY] = ready_now & ~st_q.rdy_prev;
    st_d.rdy_prev    = ready_now;
    clr        = '0;
    st_d.rdata = 8'h00;
    if (reg_req.rd) begin
      if ({reg_req.addr[7:2], 2'b00} == `IFG_CONF_BASE) begin
        st_d.rdata = (32'(reg_req.addr[1:0]) < NPIN) ? st_q.conf[reg_req.addr[1:0]] : 8'h00;
      end else if (|mlane) begin
        st_d.rdata = pick_byte(st_q.mask, reg_req.addr[1:0]);
      end else if (|flane) begin
        st_d.rdata = pick_byte(st_q.flags, reg_req.addr[1:0]);
        // RQ9 read clears the byte read
        clr = flane;
      end
    end
    if (reg_req.wr) begin
      if ({reg_req.addr[7:2], 2'b00} == `IFG_CONF_BASE && 32'(reg_req.addr[1:0]) < NPIN) begin
        st_d.conf[reg_req.addr[1:0]]    = reg_req.wdata;
        st_d.conf[reg_req.addr[1:0]][2] = 1'b0;
      end
      st_d.mask = ((st_q.mask & ~mlane) | ({4{reg_req.wdata}} & mlane)) & `IFG_USED_FLAGS;
    end
    // RQ9 a new event wins over the clear
    st_d.flags = (st_q.flags & ~clr) | ev;
    // RQ10 RQ23 request from unmasked flags
    st_d.req_n = ~|(st_d.flags & st_d.mask);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= RST_ST;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata       = st_q.rdata;
  assign event_request_n = st_q.req_n;

  always_comb begin
    src_full = src;
    // RQ11 request onto selection 0
    src_full.event_request_n = st_q.req_n;
    // RQ18 constant levels
    src_full.const_high = 1'b1;
    src_full.const_low  = 1'b0;
    // RQ19 reserved selections read low
    src_full.rsv17 = 1'b0;
    src_full.rsv31 = 1'b0;
  end

  ifg_sync3 #(
    .W (NPIN)
  ) u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (gpio_i),
    .q     (gpio_s)
  );

  // RQ12 RQ13 RQ14 RQ15 RQ16 RQ17 source order fixes each selection
  ifg_pin_mux #(
    .NPIN (NPIN)
  ) u_mux (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .conf      (st_q.conf),
    .src       (src_full),
    .pins_sync (gpio_s),
    .gpio_o    (gpio_o),
    .gpio_oe   (gpio_oe),
    .gpio_hd   (gpio_hd),
    .pin_fn    (pin_fn)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_req_follows: assert property ( // RQ23
    event_request_n == !(|(st_q.flags & st_q.mask)))
    else $error("request does not match unmasked flags");
  chk_mask_blocks: assert property ( // RQ10
    (st_q.mask == 32'h0000_0000) |-> event_request_n)
    else $error("masked event raised a request");
  chk_event_sets: assert property ( // RQ9
    events[0] |=> st_q.flags[0])
    else $error("event did not set its flag");
  chk_read_clears: assert property ( // RQ9
    (reg_req.rd && reg_req.addr == `IFG_FLAG_BASE && events[31:24] == 8'h00)
    |=> st_q.flags[31:24] == 8'h00)
    else $error("read did not clear flag byte");
  chk_read_data: assert property ( // RQ9
    (reg_req.rd && reg_req.addr == `IFG_FLAG_BASE + 8'h03)
    |=> reg_rdata == $past(st_q.flags[7:0]))
    else $error("flag read data wrong");
  chk_wut_gated: assert property ( // RQ6
    $rose(st_q.flags[`IFG_F_WUT]) |-> $past(crystal_oscillator_clk_avail))
    else $error("wake-up flag set without oscillator clock");
  chk_wut_held: assert property ( // RQ6
    (wakeup_timer_timeout && !crystal_oscillator_clk_avail) ##1
    (!crystal_oscillator_clk_avail &&
     !(reg_req.rd && {reg_req.addr[7:2], 2'b00} == `IFG_FLAG_BASE))
    [*2] ##1 crystal_oscillator_clk_avail |=> st_q.flags[`IFG_F_WUT])
    else $error("wake-up timeout lost while waiting");
  chk_ready_flag: assert property ( // RQ7
    $rose(ready_now) |=> st_q.flags[`IFG_F_READY])
    else $error("ready entry did not set flag");
  chk_undef_zero: assert property ( // RQ8
    (st_q.flags & ~`IFG_USED_FLAGS) == 32'h0000_0000)
    else $error("undefined flag position set");
  chk_pin_request: assert property ( // RQ11
    (st_q.conf[1][7:3] == `IFG_OUT_REQ && st_q.conf[1][1])
    |=> gpio_o[1] == $past(event_request_n))
    else $error("pin does not carry request");
  chk_pin_const: assert property ( // RQ18
    (st_q.conf[1][1] && st_q.conf[1][7:3] inside {`IFG_OUT_HIGH, `IFG_OUT_LOW})
    |=> gpio_o[1] == $past(st_q.conf[1][7:3] == `IFG_OUT_HIGH))
    else $error("constant selections wrong");
  chk_mode_drive: assert property ( // RQ22
    (st_q.conf[1][1:0] == ifg_pkg::ifg_mode_out_hi) |=> gpio_oe[1] && gpio_hd[1])
    else $error("high drive mode not applied");

  // a read answer stands one cycle and the port reads zero otherwise
  chk_rdata_idle: assert property ( // RQ9
    !reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data present without a read");

  chk_flag_sticky: assert property ( // RQ9
    (st_q.flags[0] && !(reg_req.rd && reg_req.addr == `IFG_FLAG_BASE + 8'h03))
    |=> st_q.flags[0])
    else $error("flag lost without a read");

  // clear on read is per byte, the other bytes keep their flags
  chk_read_keeps: assert property ( // RQ9
    (reg_req.rd && reg_req.addr == `IFG_FLAG_BASE + 8'h03)
    |=> (st_q.flags[15:8] & $past(st_q.flags[15:8])) == $past(st_q.flags[15:8]))
    else $error("read cleared another flag byte");

  chk_read_top: assert property ( // RQ9
    (reg_req.rd && reg_req.addr == `IFG_FLAG_BASE)
    |=> reg_rdata == $past(st_q.flags[31:24]))
    else $error("top flag byte read data wrong");

  chk_event_map: assert property ( // RQ1 RQ2 RQ3 RQ4 RQ5 RQ8
    (|(events & `IFG_EXT_FLAGS))
    |=> (st_q.flags & $past(events & `IFG_EXT_FLAGS)) == $past(events & `IFG_EXT_FLAGS))
    else $error("event did not set its flag position");

  chk_mask_write: assert property ( // RQ10
    (reg_req.wr && reg_req.addr == `IFG_MASK_BASE + 8'h03)
    |=> st_q.mask[7:0] == $past(reg_req.wdata))
    else $error("mask byte not written");

  chk_mask_unused: assert property ( // RQ10
    (st_q.mask & ~`IFG_USED_FLAGS) == 32'h0000_0000)
    else $error("mask bit kept at an undefined position");

  chk_rd_mask: assert property ( // RQ10
    (reg_req.rd && reg_req.addr == `IFG_MASK_BASE)
    |=> reg_rdata == $past(st_q.mask[31:24]))
    else $error("mask read data wrong");

  chk_rd_conf: assert property ( // RQ22
    (reg_req.rd && reg_req.addr == `IFG_CONF_BASE)
    |=> reg_rdata == $past(st_q.conf[0]))
    else $error("pin configuration read data wrong");

  chk_wut_clear: assert property ( // RQ6
    crystal_oscillator_clk_avail |=> !st_q.wut_pend)
    else $error("wake-up timeout still pending with clock present");

  // the ready flag comes from the entry edge, not from the level
  chk_ready_once: assert property ( // RQ7
    (ready_now && st_q.rdy_prev && !st_q.flags[`IFG_F_READY]) |=> !st_q.flags[`IFG_F_READY])
    else $error("ready flag set again without a new entry");

  // per-pin configuration and drive checks
  for (genvar g = 0; g < NPIN; g++) begin : g_pin_chk
    chk_conf_write: assert property ( // RQ22
      (reg_req.wr && reg_req.addr == `IFG_CONF_BASE + 8'(g))
      |=> st_q.conf[g] == {$past(reg_req.wdata[7:3]), 1'b0, $past(reg_req.wdata[1:0])})
      else $error("pin configuration not written");
    chk_hd_drive: assert property ( // RQ22
      gpio_hd[g] |-> gpio_oe[g])
      else $error("high drive without output enable");
    chk_pin_quiet: assert property ( // RQ22
      !gpio_oe[g] |-> !gpio_o[g])
      else $error("undriven pin shows a level");
    chk_low_drive: assert property ( // RQ22
      (st_q.conf[g][1:0] == ifg_pkg::ifg_mode_out_lo) |=> gpio_oe[g] && !gpio_hd[g])
      else $error("low drive mode not applied");
  end

  cov_req_cycle: cover property ($fell(event_request_n) ##[1:50] $rose(event_request_n));
  cov_set_on_clear: cover property (reg_req.rd && reg_req.addr == `IFG_FLAG_BASE + 8'h03
    && events[0]);
  cov_ready_flag: cover property ($rose(st_q.flags[`IFG_F_READY]));
  cov_mask_write: cover property (reg_req.wr && reg_req.addr == `IFG_MASK_BASE + 8'h03);
endmodule

/* logic/ifg_regs.svh */
`ifndef IFG_REGS_SVH
`define IFG_REGS_SVH

// register byte addresses
`define IFG_CONF_BASE   8'h00
`define IFG_MASK_BASE   8'h50
`define IFG_FLAG_BASE   8'h54

// reset values
`define IFG_CONF0_RST   8'h0a
`define IFG_CONFN_RST   8'ha2
`define IFG_MASK_RST    32'h0000_0000
`define IFG_FLAG_RST    32'h0008_0000

// flag sets: all defined flags, and those fed straight from event inputs
`define IFG_USED_FLAGS  32'h300f_ffff
`define IFG_EXT_FLAGS   32'h3006_7fff
`define IFG_LANE0_MASK  32'hff00_0000
`define IFG_LANE_SHIFT  5'd24

// derived flag positions
`define IFG_F_WUT       15
`define IFG_F_READY     16
`define IFG_F_POR       19

// input function selections
`define IFG_IN_TXCMD    5'h00
`define IFG_IN_RXCMD    5'h01
`define IFG_IN_TXDATA   5'h02
`define IFG_IN_WAKEUP   5'h03
`define IFG_IN_LFCLK    5'h04

// output selections watched by checks
`define IFG_OUT_REQ     5'h00
`define IFG_OUT_HIGH    5'h13
`define IFG_OUT_LOW     5'h14

`endif

/* logic/ifg_pkg.sv */
package ifg_pkg;

  typedef enum logic [1:0] {
    ifg_mode_off    = 2'b00,
    ifg_mode_in     = 2'b01,
    ifg_mode_out_lo = 2'b10,
    ifg_mode_out_hi = 2'b11
  } ifg_mode_t;

  typedef struct packed {
    logic [4:0] sel;
    logic       rsv;
    ifg_mode_t  mode;
  } ifg_conf_t;

  // output sources, selection 31 first down to selection 0
  typedef struct packed {
    logic rsv31, frequency_synthesizer_full, wait_cal, wait_pm, wait_osc2, onoff_keyed_tx_data, wait_lock;
    logic st_lock, st_ready, st_sleep, switching_regulator_en, const_low, const_high;
    logic txrx_active, rsv17, cs_ind, sync_ind, preamble_ind, ant_switch, st_standby;
    logic not_low_power, rx_state, rx_clk, rx_data, fifo_afull, fifo_aempty, tx_state;
    logic tx_data_clk, low_batt, wakeup_timer_expired, por_n, event_request_n;
  } ifg_src_t;

  typedef struct packed {
    logic tx_cmd;
    logic rx_cmd;
    logic tx_dm_data;
    logic ext_wakeup;
    logic ext_lf_clk;
  } ifg_pin_fn_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ifg_reg_req_t;

endpackage

/* logic/ifg_sync3.sv */
`timescale 1ns/10ps
module ifg_sync3 #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } ifg_sync_st_t;

  ifg_sync_st_t st_q;
  ifg_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // a bit is taken only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.o[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.o;
endmodule

/* logic/ifg_pin_mux.sv */
`timescale 1ns/10ps
`include "ifg_regs.svh"
module ifg_pin_mux #(
  parameter int NPIN = 4
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  wire logic [NPIN-1:0][7:0]      conf,
  input  wire ifg_pkg::ifg_src_t         src,
  input  wire logic [NPIN-1:0]           pins_sync,
  output logic      [NPIN-1:0]           gpio_o,
  output logic      [NPIN-1:0]           gpio_oe,
  output logic      [NPIN-1:0]           gpio_hd,
  output ifg_pkg::ifg_pin_fn_t           pin_fn
);
  typedef struct packed {
    logic [NPIN-1:0]      o;
    logic [NPIN-1:0]      oe;
    logic [NPIN-1:0]      hd;
    ifg_pkg::ifg_pin_fn_t fn;
  } ifg_mux_st_t;

  ifg_mux_st_t st_q;
  ifg_mux_st_t st_d;

  always_comb begin
    ifg_pkg::ifg_conf_t c;
    logic [31:0]        srcv;
    c    = '0;
    srcv = src;
    st_d = '0;
    for (int i = 0; i < NPIN; i++) begin
      c = conf[i];
      // RQ22 pin mode field
      st_d.oe[i] = (c.mode == ifg_pkg::ifg_mode_out_lo) || (c.mode == ifg_pkg::ifg_mode_out_hi);
      st_d.hd[i] = (c.mode == ifg_pkg::ifg_mode_out_hi);
      // RQ11 RQ12 RQ13 output selection
      if (st_d.oe[i]) begin
        st_d.o[i] = srcv[c.sel];
      end
      // RQ20 RQ21 input selection
      if (c.mode == ifg_pkg::ifg_mode_in) begin
        unique case (c.sel)
          `IFG_IN_TXCMD:  st_d.fn.tx_cmd     = st_d.fn.tx_cmd | pins_sync[i];
          `IFG_IN_RXCMD:  st_d.fn.rx_cmd     = st_d.fn.rx_cmd | pins_sync[i];
          `IFG_IN_TXDATA: st_d.fn.tx_dm_data = st_d.fn.tx_dm_data | pins_sync[i];
          `IFG_IN_WAKEUP: st_d.fn.ext_wakeup = st_d.fn.ext_wakeup | pins_sync[i];
          `IFG_IN_LFCLK:  st_d.fn.ext_lf_clk = st_d.fn.ext_lf_clk | pins_sync[i];
          default:        st_d.fn            = st_d.fn;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign gpio_o  = st_q.o;
  assign gpio_oe = st_q.oe;
  assign gpio_hd = st_q.hd;
  assign pin_fn  = st_q.fn;

  for (genvar g = 0; g < NPIN; g++) begin : g_in_chk
    chk_in_nodrive: assert property (@(posedge mclk) disable iff (!rst_b) // RQ22
      (conf[g][1:0] == ifg_pkg::ifg_mode_in) |=> !gpio_oe[g])
      else $error("input pin is driven");
    chk_in_txcmd: assert property (@(posedge mclk) disable iff (!rst_b) // RQ20
      (conf[g][1:0] == ifg_pkg::ifg_mode_in && conf[g][7:3] == `IFG_IN_TXCMD && pins_sync[g])
      |=> pin_fn.tx_cmd)
      else $error("high input did not raise transmit command");
  end
  cov_in_lfclk: cover property (@(posedge mclk) disable iff (!rst_b) $rose(pin_fn.ext_lf_clk));
endmodule

/* dv/ifg_host_model.sv */
`timescale 1ns/10ps
module ifg_host_model (
  input  wire logic             mclk,
  output ifg_pkg::ifg_reg_req_t reg_req,
  input  wire logic [7:0]       reg_rdata,
  output logic      [3:0]       pin_drv
);
  initial begin
    reg_req = '0;
    pin_drv = '0;
  end

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    reg_req <= '0;
  endtask

  // data is registered on the same edge that takes the read strobe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask

  task automatic set_pin(input int p, input logic v);
    @(posedge mclk);
    pin_drv[p] <= v;
  endtask
endmodule

/* dv/irq_flags_and_gpio_routing_test.sv */
`timescale 1ns/10ps
`include "ifg_regs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module irq_flags_and_gpio_routing_test;
  logic                  mclk = 1'b0;
  logic                  rst_b;
  ifg_pkg::ifg_reg_req_t reg_req;
  logic [7:0]            reg_rdata;
  logic [31:0]           events;
  logic                  wtt;
  logic                  avail;
  logic                  xo_ready;
  ifg_pkg::ifg_src_t     src;
  logic [3:0]            pin_drv;
  logic [3:0]            pin_wire;
  logic [3:0]            gpio_o;
  logic [3:0]            gpio_oe;
  logic [3:0]            gpio_hd;
  ifg_pkg::ifg_pin_fn_t  pin_fn;
  logic                  event_request_n;
  int                    miscompares = 0;
  int                    tests_run = 0;
  logic [31:0]           v;
  logic [7:0]            b;
  typedef struct {logic [31:0] ev; logic [31:0] fl;} ifg_row_t;
  ifg_row_t rows [10] = '{'{32'h1, 32'h1}, '{32'h10, 32'h10}, '{32'h40, 32'h40},
    '{32'h400, 32'h400}, '{32'h800, 32'h800}, '{32'h2000, 32'h2000},
    '{32'h20000, 32'h20000}, '{32'h2000_0000, 32'h2000_0000}, '{32'h8000, 32'h0},
    '{32'h0100_0000, 32'h0}};

  always #2.5 mclk = ~mclk;
  assign pin_wire = (gpio_oe & gpio_o) | (~gpio_oe & pin_drv);

  ifg_irq_gpio #(.NPIN(4)) ifg_irq_gpio_inst (
    .mclk                         (mclk),
    .rst_b                        (rst_b),
    .reg_req                      (reg_req),
    .reg_rdata                    (reg_rdata),
    .events                       (events),
    .wakeup_timer_timeout         (wtt),
    .crystal_oscillator_clk_avail (avail),
    .crystal_oscillator_ready     (xo_ready),
    .src                          (src),
    .gpio_i                       (pin_wire),
    .gpio_o                       (gpio_o),
    .gpio_oe                      (gpio_oe),
    .gpio_hd                      (gpio_hd),
    .pin_fn                       (pin_fn),
    .event_request_n              (event_request_n)
  );

  ifg_host_model ifg_host_model_inst (
    .mclk      (mclk),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata),
    .pin_drv   (pin_drv)
  );

  task automatic read32(output logic [31:0] r);
    logic [7:0] t;
    for (int i = 0; i < 4; i++) begin
      ifg_host_model_inst.reg_read(`IFG_FLAG_BASE + 8'(i), t);
      r = {r[23:0], t};
    end
  endtask

  task automatic pulse(input logic [31:0] ev);
    @(posedge mclk);
    events <= ev;
    @(posedge mclk);
    events <= '0;
    #1;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    close_out();
  end

  initial begin
    rst_b = 1'b0; events = '0; wtt = 1'b0; avail = 1'b1; xo_ready = 1'b0; src = '0;
    settle(5);
    `CHK("request in reset", 1'b1, event_request_n);
    rst_b <= 1'b1;
    settle(1);
    `CHK("drive after reset", 4'hf, gpio_oe);
    read32(v);
    `CHK("flags after reset", 32'h0008_0000, v);
    ifg_host_model_inst.reg_read(`IFG_CONF_BASE, b);
    `CHK("conf0 reset", 8'h0a, b);
    for (int i = 0; i < 4; i++) ifg_host_model_inst.reg_write(`IFG_MASK_BASE + 8'(i), 8'hff);
    $display("test reset done");
    for (int i = 0; i < $size(rows); i++) begin
      pulse(rows[i].ev);
      settle(1);
      `CHK("request", rows[i].fl == 0, event_request_n);
      read32(v);
      `CHK("flags", rows[i].fl, v);
      read32(v);
      `CHK("flags cleared", 32'h0, v);
      `CHK("request released", 1'b1, event_request_n);
    end
    $display("test flag rows done");
    ifg_host_model_inst.reg_write(`IFG_FLAG_BASE - 8'h1, 8'hfe);
    pulse(32'h1);
    settle(1);
    `CHK("masked request", 1'b1, event_request_n);
    pulse(32'h2);
    ifg_host_model_inst.reg_write(`IFG_CONF_BASE + 8'h1, 8'h03);
    settle(2);
    `CHK("pin request", 1'b0, gpio_o[1]);
    `CHK("high drive", 4'h2, gpio_hd);
    read32(v);
    `CHK("masked flag kept", 32'h3, v);
    $display("test mask done");
    @(posedge mclk);
    wtt <= 1'b1;
    avail <= 1'b0;
    @(posedge mclk);
    wtt <= 1'b0;
    settle(2);
    `CHK("wake flag held", 1'b1, event_request_n);
    avail <= 1'b1;
    settle(2);
    read32(v);
    `CHK("wake flag", 32'h8000, v);
    src.st_ready <= 1'b1;
    xo_ready <= 1'b1;
    settle(3);
    read32(v);
    `CHK("ready flag", 32'h1_0000, v);
    read32(v);
    `CHK("ready once", 32'h0, v);
    $display("test derived flags done");
    for (int k = 1; k < 32; k++) begin
      src <= ifg_pkg::ifg_src_t'(32'h1 << k);
      ifg_host_model_inst.reg_write(`IFG_CONF_BASE + 8'h1, {5'(k), 3'b010});
      settle(2);
      `CHK("out sel one", !(k inside {17, 20, 31}), gpio_o[1]);
      src <= ifg_pkg::ifg_src_t'(~(32'h1 << k));
      settle(2);
      `CHK("out sel zero", k == 19, gpio_o[1]);
    end
    $display("test output select done");
    for (int j = 0; j < 6; j++) begin
      ifg_host_model_inst.reg_write(`IFG_CONF_BASE + 8'h2, {5'(j), 3'b001});
      ifg_host_model_inst.set_pin(2, 1'b1);
      settle(6);
      `CHK("input fn", (j < 5) ? 5'h10 >> j : 5'h0, pin_fn);
      ifg_host_model_inst.set_pin(2, 1'b0);
      settle(6);
      `CHK("input fn idle", 5'h0, pin_fn);
    end
    $display("test input select done");
    ifg_host_model_inst.reg_write(`IFG_CONF_BASE + 8'h3, 8'hfc);
    ifg_host_model_inst.reg_read(`IFG_CONF_BASE + 8'h3, b);
    `CHK("conf reserved bit", 8'hf8, b);
    `CHK("mode off", 1'b0, gpio_oe[3]);
    ifg_host_model_inst.reg_read(8'h80, b);
    `CHK("unmapped", 8'h00, b);
    ifg_host_model_inst.reg_read(`IFG_MASK_BASE, b);
    `CHK("mask top byte", 8'h30, b);
    $display("test registers done");
    src <= '0;
    settle(1);
    rst_b <= 1'b0;
    settle(2);
    `CHK("request in second reset", 1'b1, event_request_n);
    `CHK("drive in second reset", 4'h0, gpio_oe);
    rst_b <= 1'b1;
    settle(1);
    `CHK("drive after second reset", 4'hf, gpio_oe);
    read32(v);
    `CHK("flags after second reset", 32'h0008_0000, v);
    ifg_host_model_inst.reg_read(`IFG_CONF_BASE + 8'h3, b);
    `CHK("conf3 after second reset", 8'ha2, b);
    $display("test second reset done");
    close_out();
  end
endmodule
